// ---- design/adcof_top.v ----
// Output formatter and power mode control of a 14-bit sampling converter.
// Assumes raw results arrive as 15-bit signed codes (beyond range = out).
//
// Contract
// - Offset binary, midscale 0x2000, one code per step.
// - Two's complement is offset binary with MSB inverted.
// - Clamp out-of-range input, raise overrange flag.
// - Mode levels 0,1 offset binary; 2,3 two's complement.
// - Stabilizer on at levels 1 and 2 only.
// - Output enable high tri-states data and flag.
// - Power-down select low means normal conversion.
// - Power-down and enable high give sleep mode.
// - Nap keeps reference; valid about 100 cycles later.
// - Sleep and nap tri-state all digital outputs; here only word and flag float, data_valid and irq stay driven.
// - Stabilizer samples rising edge, makes 50% duty.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "adcof_regs.vh"
module adcof_top #(
  parameter DW = 14,
  parameter SLEEP_CYCLES = `ADCOF_SLEEP_CYCLES,
  parameter NAP_CYCLES = `ADCOF_NAP_CYCLES,
  parameter LOCK_CYCLES = `ADCOF_LOCK_CYCLES
) (
  input wire ref_clk,
  input wire reset,
  // Conversion source and sample clock.
  input wire sample_clk,
  input wire signed [DW:0] raw_code,
  // Parallel output pins, two signals each; enable low means driving.
  output reg [DW-1:0] sample_word_bits,
  output reg [DW-1:0] sample_word_bits_oe_n,
  output reg overrange_flag,
  output reg overrange_flag_oe_n,
  output reg data_valid,
  output reg irq,
  // AXI4-Lite slave.
  input wire [`ADCOF_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADCOF_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam RW = 24;
  localparam [1:0] RESP_OK = 2'b00;
  localparam [1:0] RESP_ERR = 2'b10;
  // Extremes of the signed raw code at the data width.
  localparam signed [DW:0] MAX_CODE = {2'b00, {(DW-1){1'b1}}};
  localparam signed [DW:0] MIN_CODE = {2'b11, {(DW-1){1'b0}}};

  reg [31:0] ctrl;
  reg [`ADCOF_IRQ_W-1:0] irq_stat;
  reg [`ADCOF_IRQ_W-1:0] irq_en;
  reg [1:0] pmode;
  reg [1:0] next_pmode;
  reg sclk_d;
  reg dcs_phase;
  reg [DW-1:0] last_word;
  reg last_ovr;
  reg valid_d;
  reg rec_sleep;
  reg [DW-1:0] next_word;
  reg next_ovr;
  reg [RW-1:0] rec_len;
  reg [RW-1:0] lock_len;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg aw_held;
  reg w_held;
  reg [`ADCOF_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [1:0] mode_lvl;
  wire twos;
  wire dcs_on;
  wire oe_n_pin;
  wire pds;
  wire sample_en;
  wire rec_busy;
  wire lock_busy;
  wire rec_start;
  wire do_write;
  wire ovr_event;
  wire valid_event;

  // Gives the offset binary code of a signed result; MSB flip of two's.
  function [DW-1:0] adcof_offset;
    input signed [DW:0] v;
    begin
      adcof_offset = v[DW-1:0] ^ {1'b1, {(DW-1){1'b0}}};
    end
  endfunction

  // Byte-lane merge for register writes.
  function [31:0] adcof_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      adcof_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          adcof_merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Mode level and pins come from the control register, as there is no
  // analog level sensing here; level 0..3 stands for ground..supply.
  assign mode_lvl = ctrl[`ADCOF_CTRL_MODE_LSB +: 2];
  assign twos = mode_lvl[1];
  assign dcs_on = mode_lvl[0] ^ mode_lvl[1];
  assign oe_n_pin = ctrl[`ADCOF_CTRL_OE_N_BIT];
  assign pds = ctrl[`ADCOF_CTRL_PDS_BIT];

  // Power mode decode from the two pins.
  always @* begin
    if (!pds) begin
      next_pmode = `ADCOF_PM_NORMAL;
    end else if (oe_n_pin) begin
      next_pmode = `ADCOF_PM_SLEEP;
    end else begin
      next_pmode = `ADCOF_PM_NAP;
    end
  end

  // Sample clock arrives synchronous to ref_clk; a rising edge makes the
  // sample enable. With the stabilizer on only the rising edge counts and
  // an internal phase toggles per edge, giving an even 50% duty.
  always @(posedge ref_clk) begin
    if (reset) begin
      sclk_d <= 1'b0;
      dcs_phase <= 1'b0;
    end else begin
      sclk_d <= sample_clk;
      if (sample_en && dcs_on) begin
        dcs_phase <= ~dcs_phase;
      end
    end
  end
  assign sample_en = sample_clk && !sclk_d && (pmode == `ADCOF_PM_NORMAL);

  // Word and flag formed from one result so they always agree.
  always @* begin
    if (raw_code > MAX_CODE) begin
      next_word = adcof_offset(MAX_CODE);
      next_ovr = 1'b1;
    end else if (raw_code < MIN_CODE) begin
      next_word = adcof_offset(MIN_CODE);
      next_ovr = 1'b1;
    end else begin
      next_word = adcof_offset(raw_code);
      next_ovr = 1'b0;
    end
    if (twos) begin
      next_word[DW-1] = ~next_word[DW-1];
    end
  end

  // Recovery lengths depend on the mode being left; sleep recharges the
  // reference, so it is far longer than a nap.
  always @* begin
    rec_len = {RW{1'b0}};
    if (pmode == `ADCOF_PM_SLEEP) begin
      rec_len = SLEEP_CYCLES[RW-1:0];
    end else if (pmode == `ADCOF_PM_NAP) begin
      rec_len = NAP_CYCLES[RW-1:0];
    end
    lock_len = LOCK_CYCLES[RW-1:0];
  end

  // Sleep recovery counts ref_clk cycles since the sample clock may be
  // slow; nap and lock recovery count sample clock cycles. The mode being
  // left is remembered, as pmode is already normal while counting.
  assign rec_start = pmode != `ADCOF_PM_NORMAL && next_pmode == `ADCOF_PM_NORMAL;
  adcof_recover #(.CW(RW)) u_rec (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(rec_start),
    .length(rec_len),
    .tick(rec_sleep || sample_en),
    .busy(rec_busy)
  );

  // The lock window restarts when a power mode ends with the stabilizer on.
  adcof_recover #(.CW(RW)) u_lock (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(dcs_on && rec_start),
    .length(lock_len),
    .tick(sample_en),
    .busy(lock_busy)
  );

  // Output pins and capture; word and flag change on the same edge.
  always @(posedge ref_clk) begin
    if (reset) begin
      pmode <= `ADCOF_PM_SLEEP; // Matches the control reset, so no false valid.
      rec_sleep <= 1'b0;
      last_word <= `ADCOF_MIDSCALE;
      last_ovr <= 1'b0;
      sample_word_bits <= `ADCOF_MIDSCALE;
      overrange_flag <= 1'b0;
      sample_word_bits_oe_n <= {DW{1'b1}};
      overrange_flag_oe_n <= 1'b1;
      data_valid <= 1'b0;
      valid_d <= 1'b0;
    end else begin
      pmode <= next_pmode;
      if (rec_start) begin
        rec_sleep <= (pmode == `ADCOF_PM_SLEEP);
      end
      if (sample_en) begin
        last_word <= next_word;
        last_ovr <= next_ovr;
        sample_word_bits <= next_word;
        overrange_flag <= next_ovr;
      end
      // Output enable high or any power-down mode floats the word and flag pins.
      sample_word_bits_oe_n <= {DW{oe_n_pin || next_pmode != `ADCOF_PM_NORMAL}};
      overrange_flag_oe_n <= oe_n_pin || next_pmode != `ADCOF_PM_NORMAL;
      data_valid <= pmode == `ADCOF_PM_NORMAL && !rec_busy && !(dcs_on && lock_busy);
      valid_d <= data_valid;
    end
  end

  assign ovr_event = sample_en && next_ovr;
  assign valid_event = data_valid && !valid_d;

  // AXI4-Lite write: address and data taken in either order, then answer.
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always @(posedge ref_clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`ADCOF_ADDR_W{1'b0}};
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= `ADCOF_CTRL_RESET;
      irq_en <= {`ADCOF_IRQ_W{1'b0}};
      irq_stat <= {`ADCOF_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Clearing goes first so that a same-cycle event still sets.
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OK;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        case (aw_addr)
          `ADCOF_CTRL_ADDR: begin
            ctrl <= adcof_merge(ctrl, w_data, w_strb) & 32'h0000_000f;
          end
          `ADCOF_IRQ_EN_ADDR: begin
            irq_en <= w_strb[0] ? w_data[`ADCOF_IRQ_W-1:0] : irq_en;
          end
          `ADCOF_IRQ_CLR_ADDR: begin
            irq_stat <= (w_strb[0] ? irq_stat & ~w_data[`ADCOF_IRQ_W-1:0] : irq_stat)
              | {valid_event, ovr_event};
          end
          `ADCOF_STATUS_ADDR, `ADCOF_IRQ_STAT_ADDR, `ADCOF_SAMPLE_ADDR: begin
            s_axi_bresp <= RESP_OK;
          end
          default: begin
            s_axi_bresp <= RESP_ERR;
          end
        endcase
      end
      if (!(do_write && aw_addr == `ADCOF_IRQ_CLR_ADDR)) begin
        irq_stat <= irq_stat | {valid_event, ovr_event};
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // Read decode of registers showing the block's own state.
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `ADCOF_CTRL_ADDR: rd_mux = ctrl;
      `ADCOF_STATUS_ADDR: begin
        rd_mux[`ADCOF_ST_TWOS_BIT] = twos;
        rd_mux[`ADCOF_ST_DCS_BIT] = dcs_on;
        rd_mux[`ADCOF_ST_PMODE_LSB +: 2] = pmode;
        rd_mux[`ADCOF_ST_VALID_BIT] = data_valid;
        rd_mux[`ADCOF_ST_LOCK_BIT] = dcs_on && !lock_busy;
        rd_mux[`ADCOF_ST_PHASE_BIT] = dcs_phase;
      end
      `ADCOF_IRQ_STAT_ADDR: rd_mux[`ADCOF_IRQ_W-1:0] = irq_stat;
      `ADCOF_IRQ_EN_ADDR: rd_mux[`ADCOF_IRQ_W-1:0] = irq_en;
      `ADCOF_IRQ_CLR_ADDR: rd_mux = 32'h0000_0000;
      `ADCOF_SAMPLE_ADDR: rd_mux = {15'h0000, last_ovr, 2'h0, last_word};
      default: rd_hit = 1'b0;
    endcase
  end

  // AXI4-Lite read: one read at a time, answer the cycle after the take.
  always @(posedge ref_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // adcof_top

// ---- pkg/adcof_regs.vh ----
// Constants for the converter output formatter: register offsets, fields,
// reset values and timing counts. Included by the top design file and the testbench by bare name.
`ifndef ADCOF_REGS_VH
`define ADCOF_REGS_VH
// Register byte offsets on the AXI4-Lite slave.
`define ADCOF_CTRL_ADDR 5'h00
`define ADCOF_STATUS_ADDR 5'h04
`define ADCOF_IRQ_STAT_ADDR 5'h08
`define ADCOF_IRQ_EN_ADDR 5'h0c
`define ADCOF_IRQ_CLR_ADDR 5'h10
`define ADCOF_SAMPLE_ADDR 5'h14
`define ADCOF_ADDR_W 5
// Control register fields.
`define ADCOF_CTRL_MODE_LSB 0
`define ADCOF_CTRL_OE_N_BIT 2
`define ADCOF_CTRL_PDS_BIT 3
`define ADCOF_CTRL_RESET 32'h0000_000c
// Status register fields.
`define ADCOF_ST_TWOS_BIT 0
`define ADCOF_ST_DCS_BIT 1
`define ADCOF_ST_PMODE_LSB 2
`define ADCOF_ST_VALID_BIT 4
`define ADCOF_ST_LOCK_BIT 5
`define ADCOF_ST_PHASE_BIT 6
// Interrupt status bits.
`define ADCOF_IRQ_OVR_BIT 0
`define ADCOF_IRQ_VALID_BIT 1
`define ADCOF_IRQ_W 2
// Power modes.
`define ADCOF_PM_NORMAL 2'h0
`define ADCOF_PM_NAP 2'h1
`define ADCOF_PM_SLEEP 2'h2
// Codes.
`define ADCOF_MIDSCALE 14'h2000
`define ADCOF_FULL_POS 14'h3fff
`define ADCOF_FULL_NEG 14'h0000
// Timing: clock period in ns, recovery figures.
`define ADCOF_CLK_NS 40
`define ADCOF_NAP_CYCLES 100
`define ADCOF_LOCK_CYCLES 100
`define ADCOF_SLEEP_MS 2
`define ADCOF_SLEEP_CYCLES ((`ADCOF_SLEEP_MS * 1000000) / `ADCOF_CLK_NS)
`endif

// ---- design/adcof_recover.v ----
// Recovery timer: counts tick pulses (sample enables, or ref_clk cycles after sleep) after a power mode ends.
// Assumes one clock; sample_en is a one-cycle pulse per conversion.
`timescale 1ns/1ps
module adcof_recover #(
  parameter CW = 16
) (
  input wire ref_clk,
  input wire reset,
  input wire start,
  input wire [CW-1:0] length,
  input wire tick,
  output reg busy
);
  reg [CW-1:0] count;

  // A start reloads the count; busy falls after the given number of ticks.
  always @(posedge ref_clk) begin
    if (reset) begin
      count <= {CW{1'b0}};
      busy <= 1'b0;
    end else if (start) begin
      count <= length;
      busy <= (length != {CW{1'b0}});
    end else if (busy && tick) begin
      count <= count - {{(CW-1){1'b0}}, 1'b1};
      busy <= (count != {{(CW-1){1'b0}}, 1'b1});
    end
  end
endmodule // adcof_recover

// ---- tb/adcof_capture.sv ----
// Capture model: the logic that latches the parallel words on each clock.
// Assumes the word and flag pins of the formatter are wired straight to it.
`timescale 1ns/1ps
module adcof_capture (
  input wire ref_clk,
  input wire [13:0] word,
  input wire [13:0] word_oe_n,
  input wire flag,
  input wire flag_oe_n,
  input wire valid,
  output reg [13:0] cap_word,
  output reg cap_flag,
  output reg cap_ok
);
  // Released lines show the inverse of the last capture, so a float is never read as data.
  wire [13:0] line_word = (word & ~word_oe_n) | (~cap_word & word_oe_n);
  wire line_flag = flag_oe_n ? ~cap_flag : flag;
  initial cap_word = 14'h0;
  initial cap_flag = 1'b0;
  initial cap_ok = 1'b0;
  // Data are trusted only while the converter reports recovery done.
  always @(posedge ref_clk) begin
    cap_word <= line_word;
    cap_flag <= line_flag;
    cap_ok <= valid;
  end
endmodule // adcof_capture

// ---- tb/adcof_top_sva.sv ----
// Checker for the formatter's output pins and register bus handshakes.
// Assumes it is bound to adcof_top and sees only that module's ports.
`timescale 1ns/1ps
module adcof_top_sva #(
  parameter DW = 14
) (
  input wire ref_clk,
  input wire reset,
  input wire sample_clk,
  input wire signed [DW:0] raw_code,
  input wire [DW-1:0] sample_word_bits,
  input wire [DW-1:0] sample_word_bits_oe_n,
  input wire overrange_flag,
  input wire overrange_flag_oe_n,
  input wire data_valid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // A conversion is taken on a sample clock rise in normal mode.
  sequence s_take;
    $rose(sample_clk) && data_valid;
  endsequence
  sequence s_idle;
    !$rose(sample_clk);
  endsequence
  in_range_a: assert property (s_take ##0 (raw_code <= 8191 && raw_code >= -8192) |=>
    sample_word_bits[12:0] == $past(raw_code[12:0]) && !overrange_flag) else $error("word wrong");
  clamp_high_a: assert property (s_take ##0 (raw_code > 8191) |=>
    overrange_flag && (&sample_word_bits[12:0])) else $error("no high clamp");
  clamp_low_a: assert property (s_take ##0 (raw_code < -8192) |=>
    overrange_flag && sample_word_bits[12:0] == 13'h0) else $error("no low clamp");
  word_hold_a: assert property (s_idle |=>
    $stable(sample_word_bits) && $stable(overrange_flag)) else $error("word moved");
  float_together_a: assert property (
    sample_word_bits_oe_n == {DW{overrange_flag_oe_n}}) else $error("enables differ");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
endmodule // adcof_top_sva
bind adcof_top adcof_top_sva #(.DW(DW)) adcof_top_sva_i (.ref_clk(ref_clk), .reset(reset),
  .sample_clk(sample_clk), .raw_code(raw_code), .sample_word_bits(sample_word_bits),
  .sample_word_bits_oe_n(sample_word_bits_oe_n), .overrange_flag(overrange_flag),
  .overrange_flag_oe_n(overrange_flag_oe_n), .data_valid(data_valid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- tb/adc_output_format_and_power_modes_tb_top.sv ----
// Testbench for the formatter: register bus master, sample source, result checks.
// Assumes adcof_capture as the far side and the checker bound to the design.
`timescale 1ns/1ps
`include "adcof_regs.vh"
module adc_output_format_and_power_modes_tb_top;
  reg ref_clk = 0, reset = 1, sample_clk = 0;
  reg signed [14:0] raw_code = 0;
  reg [4:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, rd;
  reg [1:0] r;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, flag, flag_oe_n, valid, irq, cap_flag, cap_ok;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [13:0] word, word_oe_n, cap_word;
  int n_mismatch = 0, n_compared = 0, n, k, m, v;
  int corner [7] = '{0, 1, -1, 8191, 8192, -8192, -8193};
  // Short recovery counts keep the run brief; expectations follow them.
  adcof_top #(.SLEEP_CYCLES(20), .NAP_CYCLES(4), .LOCK_CYCLES(4)) adcof_top_i (
    .ref_clk(ref_clk), .reset(reset), .sample_clk(sample_clk), .raw_code(raw_code),
    .sample_word_bits(word), .sample_word_bits_oe_n(word_oe_n), .overrange_flag(flag),
    .overrange_flag_oe_n(flag_oe_n), .data_valid(valid), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  adcof_capture adcof_capture_i (.ref_clk(ref_clk), .word(word), .word_oe_n(word_oe_n),
    .flag(flag), .flag_oe_n(flag_oe_n), .valid(valid), .cap_word(cap_word),
    .cap_flag(cap_flag), .cap_ok(cap_ok));
  // Free-running 25 MHz clock.
  always #20 ref_clk = ~ref_clk;
  task chk(input [31:0] seen, input [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Address and data are offered together; each is released once taken.
  task wr(input [4:0] a, input [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (awvalid && !awready || wvalid && !wready);
    do @(posedge ref_clk); while (!bvalid);
    bready <= 0;
    @(posedge ref_clk);
  endtask
  task rd_reg(input [4:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 0;
    do @(posedge ref_clk); while (!rvalid);
    rd = rdata;
    r = rresp;
    rready <= 0;
    @(posedge ref_clk);
  endtask
  // One conversion: a one-cycle sample clock high, then time to land and be captured.
  task pulse(input int x);
    sample_clk <= 1;
    raw_code <= x[14:0];
    @(posedge ref_clk);
    sample_clk <= 0;
    repeat (3) @(posedge ref_clk);
  endtask
  task recover;
    n = 0;
    while (!valid && n < 60) begin
      pulse(0);
      n++;
    end
  endtask
  function [14:0] fmt(input int x, input bit twos);
    reg [13:0] ob;
    ob = x > 8191 ? 14'h3fff : x < -8192 ? 14'h0 : 14'(x + 8192);
    fmt = {x > 8191 || x < -8192, ob ^ {twos, 13'h0}};
  endfunction
  // Main sequence: reset state, formats, interrupts, enable and power modes.
  initial begin
    void'($urandom(32'h8619));
    repeat (12) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk);
    chk(word_oe_n, 14'h3fff);
    rd_reg(`ADCOF_CTRL_ADDR);
    chk(rd, 32'hc);
    rd_reg(`ADCOF_STATUS_ADDR);
    chk(rd[3:2], 2'h2);
    rd_reg(5'h18);
    chk(r, 2'h2);
    wr(`ADCOF_IRQ_EN_ADDR, 3);
    for (m = 0; m < 4; m++) begin
      wr(`ADCOF_CTRL_ADDR, m);
      recover;
      rd_reg(`ADCOF_STATUS_ADDR);
      chk(rd[4:0], {1'b1, 2'b00, m == 1 || m == 2, m > 1});
      for (k = 0; k < 12; k++) begin
        v = k < 7 ? corner[k] : int'($urandom_range(18000)) - 9000;
        pulse(v);
        chk({cap_flag, cap_word}, fmt(v, m > 1));
      end
    end
    chk(irq, 1);
    wr(`ADCOF_IRQ_EN_ADDR, 0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    wr(5'h10, 3);
    chk(bresp, 2'h0);
    wr(`ADCOF_IRQ_EN_ADDR, 1);
    rd_reg(`ADCOF_IRQ_STAT_ADDR);
    chk(rd[1:0], 0);
    pulse(9000);
    chk(irq, 1);
    // Output enable high, nap and sleep each float the word and flag pins.
    wr(`ADCOF_CTRL_ADDR, 4);
    repeat (2) @(posedge ref_clk);
    chk({flag_oe_n, word_oe_n}, 15'h7fff);
    wr(`ADCOF_CTRL_ADDR, 8);
    repeat (2) @(posedge ref_clk);
    rd_reg(`ADCOF_STATUS_ADDR);
    chk(rd[3:2], 2'h1);
    chk({flag_oe_n, word_oe_n}, 15'h7fff);
    wr(`ADCOF_CTRL_ADDR, 0);
    recover;
    chk(n >= 4 && valid, 1);
    wr(`ADCOF_CTRL_ADDR, 12);
    repeat (2) @(posedge ref_clk);
    chk({flag_oe_n, word_oe_n}, 15'h7fff);
    wr(`ADCOF_CTRL_ADDR, 0);
    recover;
    chk(n >= 5 && valid, 1);
    chk(cap_ok, 1);
    end_sim;
  end
  // A hang ends the run as a failure.
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    end_sim;
  end
endmodule // adc_output_format_and_power_modes_tb_top
